//--- core/adcc_conversion_control.sv
/*
 * Control, sequencing and result registers of a 10-bit successive
 * approximation converter, reached over the CPU I/O bus.
 * Assumes: I/O strobes are one-cycle, synchronous to clock; the analog
 * core holds sarResult valid on the cycle the conversion ends; event
 * flags and the global interrupt enable are synchronous levels.
 */
`timescale 1ns/10ps
`default_nettype none
`include "adcc_params.svh"

module adcc_conversion_control (
   input wire logic clock,
   input wire logic nrst,
   input wire adcc_pkg::adcc_io_req_t ioReq,
   output logic [7:0] ioRdata,
   input wire adcc_pkg::adcc_trig_flags_t trigFlags,
   input wire logic globalIrqEnable,
   input wire logic irqVectorAck,
   input wire logic [9:0] sarResult,
   output logic irqRequest,
   output logic converterOn,
   output logic convStart,
   output logic [4:0] activeChannel,
   output logic [1:0] activeReference
);
   import adcc_pkg::*;

   // ==========================================================
   // Helpers
   // Prescaler terminal count: divisor minus one
   function automatic logic [6:0] presTop(input logic [2:0] sel);
      logic [2:0] sh;
      sh = (sel < `ADCC_PS_MIN_SHIFT) ? `ADCC_PS_MIN_SHIFT : sel;
      presTop = 7'((8'h01 << sh) - 8'h01);
   endfunction

   // ==========================================================
   // State
   logic enable_q, autoTrig_q, irqEn_q, doneFlag_q, firstPend_q, longConv_q;
   logic [2:0] presSel_q, trigSel_q;
   logic [7:0] muxReg_q;
   logic [9:0] result_q;
   logic lock_q, trigPrev_q;
   logic [6:0] presCnt_q;
   logic [4:0] convCnt_q;
   adcc_state_t state_q;
   logic [7:0] ioRdata_q;
   logic irq_q, conv_q, start_q;
   logic [4:0] chan_q;
   logic [1:0] ref_q;

   // ==========================================================
   // Bus decode
   logic wrCsr, wrMux, wrSfio, rdLow, rdHigh;
   assign wrCsr = ioReq.wr && (ioReq.addr == `ADCC_OFF_CSR);
   assign wrMux = ioReq.wr && (ioReq.addr == `ADCC_OFF_MUX);
   assign wrSfio = ioReq.wr && (ioReq.addr == `ADCC_OFF_SFIO);
   assign rdLow = ioReq.rd && (ioReq.addr == `ADCC_OFF_RESL);
   assign rdHigh = ioReq.rd && (ioReq.addr == `ADCC_OFF_RESH);

   // ==========================================================
   // Sequencing terms
   logic enNext, busy, tick, convDone, swStart, trigSig, trigEdge;
   logic freeRun, startNow, abort;
   logic [4:0] convLimit;
   assign enNext = wrCsr ? ioReq.wdata[`ADCC_CSR_EN] : enable_q;
   assign abort = enable_q && !enNext;
   assign busy = (state_q == ADCC_CONV);
   assign tick = (presCnt_q == presTop(presSel_q));
   assign convLimit = longConv_q ? `ADCC_FIRST_CYCLES : `ADCC_NORM_CYCLES;
   assign convDone = busy && tick && (convCnt_q == convLimit - 5'd1);
   // A zero written to the start bit never reaches startNow
   assign swStart = wrCsr && ioReq.wdata[`ADCC_CSR_SC];
   // Select code 0 feeds no flag, so free running makes no edge
   assign trigSig = autoTrig_q && (trigSel_q != `ADCC_TS_FREE) &&
                    trigFlags[trigSel_q - 3'h1];
   assign trigEdge = trigSig && !trigPrev_q;
   assign freeRun = autoTrig_q && (trigSel_q == `ADCC_TS_FREE);
   // Requests during a running conversion are dropped unless it ends that cycle
   assign startNow = enNext && (!busy || convDone) &&
                     (swStart || trigEdge || (convDone && freeRun));

   // ==========================================================
   // Control register fields
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         enable_q <= 1'b0;
         autoTrig_q <= 1'b0;
         irqEn_q <= 1'b0;
         presSel_q <= 3'h0;
      end else if (wrCsr) begin
         enable_q <= ioReq.wdata[`ADCC_CSR_EN];
         autoTrig_q <= ioReq.wdata[`ADCC_CSR_ATE];
         irqEn_q <= ioReq.wdata[`ADCC_CSR_IE];
         presSel_q <= ioReq.wdata[`ADCC_CSR_PS];
      end
   end

   // Channel, reference and justify bits; justify resets to right
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         muxReg_q <= `ADCC_RST_BYTE;
      end else if (wrMux) begin
         muxReg_q <= ioReq.wdata;
      end
   end

   // Trigger select field
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         trigSel_q <= 3'h0;
      end else if (wrSfio) begin
         trigSel_q <= ioReq.wdata[`ADCC_SFIO_TS];
      end
   end

   // ==========================================================
   // Done flag: hardware set wins over write-one or vector clear
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         doneFlag_q <= 1'b0;
      end else if (convDone) begin
         doneFlag_q <= 1'b1;
      end else if ((wrCsr && ioReq.wdata[`ADCC_CSR_IF]) || irqVectorAck) begin
         doneFlag_q <= 1'b0;
      end
   end

   // ==========================================================
   // Prescaler runs only while enabled, so the first conversion after
   // power up starts from a known phase
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         presCnt_q <= 7'h00;
      end else if (!enable_q || tick) begin
         presCnt_q <= 7'h00;
      end else begin
         presCnt_q <= presCnt_q + 7'h01;
      end
   end

   // Pending initialisation: set when the converter is switched on without a start in the same cycle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         firstPend_q <= 1'b0;
      end else if (!enable_q && enNext) begin
         firstPend_q <= !startNow;
      end else if (startNow) begin
         firstPend_q <= 1'b0;
      end
   end

   // ==========================================================
   // Conversion sequencer
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q <= ADCC_IDLE;
         convCnt_q <= 5'h00;
         longConv_q <= 1'b0;
      end else begin
         case (state_q)
            ADCC_IDLE: begin
               if (startNow) begin
                  state_q <= ADCC_CONV;
                  convCnt_q <= 5'h00;
                  longConv_q <= firstPend_q || !enable_q;
               end
            end
            ADCC_CONV: begin
               if (abort) begin
                  state_q <= ADCC_IDLE;
               end else if (convDone) begin
                  convCnt_q <= 5'h00;
                  longConv_q <= 1'b0;
                  if (!startNow) begin
                     state_q <= ADCC_IDLE;
                  end
               end else if (tick) begin
                  convCnt_q <= convCnt_q + 5'h01;
               end
            end
            default: begin
               state_q <= ADCC_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Trigger history, sampled every cycle so a source switch is seen
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         trigPrev_q <= 1'b0;
      end else begin
         trigPrev_q <= trigSig;
      end
   end

   // ==========================================================
   // Result store; the analog core already gives two's complement for
   // differential channels, so the bits are kept as delivered
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         result_q <= `ADCC_RST_RES;
      end else if (convDone && !lock_q) begin
         result_q <= sarResult;
      end
   end

   // Read lock: a low-byte read freezes the pair until the high read
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lock_q <= 1'b0;
      end else if (rdHigh) begin
         lock_q <= 1'b0;
      end else if (rdLow) begin
         lock_q <= 1'b1;
      end
   end

   // ==========================================================
   // Read data; justification applied at read time so a change of the
   // justify bit shows at once
   logic [7:0] rdMux;
   logic lar;
   assign lar = muxReg_q[`ADCC_MUX_LAR];
   always_comb begin
      rdMux = `ADCC_RST_BYTE;
      case (ioReq.addr)
         `ADCC_OFF_RESL: rdMux = lar ? {result_q[1:0], 6'h00} : result_q[7:0];
         `ADCC_OFF_RESH: rdMux = lar ? result_q[9:2] : {6'h00, result_q[9:8]};
         `ADCC_OFF_CSR: rdMux = {enable_q, busy, autoTrig_q, doneFlag_q,
                                 irqEn_q, presSel_q};
         `ADCC_OFF_MUX: rdMux = muxReg_q;
         `ADCC_OFF_SFIO: rdMux = {trigSel_q, 5'h00};
         default: rdMux = `ADCC_RST_BYTE;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ioRdata_q <= `ADCC_RST_BYTE;
      end else if (ioReq.rd) begin
         ioRdata_q <= rdMux;
      end
   end

   // ==========================================================
   // Outputs to the analog core and the interrupt controller
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_q <= 1'b0;
         conv_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         irq_q <= doneFlag_q && irqEn_q && globalIrqEnable;
         conv_q <= enNext;
         start_q <= startNow;
      end
   end

   // Channel and reference only move while no conversion runs
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         chan_q <= 5'h00;
         ref_q <= 2'h0;
      end else if (!busy || convDone) begin
         chan_q <= muxReg_q[`ADCC_MUX_CH];
         ref_q <= muxReg_q[`ADCC_MUX_REF];
      end
   end

   assign ioRdata = ioRdata_q;
   assign irqRequest = irq_q;
   assign converterOn = conv_q;
   assign convStart = start_q;
   assign activeChannel = chan_q;
   assign activeReference = ref_q;

   // ==========================================================
   // Checks
   a_abort_on_disable: assert property (@(posedge clock) disable iff (!nrst)
      (busy && abort) |=> !busy) else $error("conversion not aborted");
   a_start_sets_busy: assert property (@(posedge clock) disable iff (!nrst)
      (!busy && swStart && enNext) |=> busy ##0 convStart) else $error("start lost");
   a_first_is_long: assert property (@(posedge clock) disable iff (!nrst)
      (!enable_q && enNext) |=> (busy ? longConv_q : firstPend_q))
      else $error("first conversion not long");
   a_flag_on_done: assert property (@(posedge clock) disable iff (!nrst)
      convDone |=> doneFlag_q) else $error("done flag not set");
   a_irq_gate: assert property (@(posedge clock) disable iff (!nrst)
      ##1 irqRequest == $past(doneFlag_q && irqEn_q && globalIrqEnable))
      else $error("irq gating wrong");
   a_flag_w1c: assert property (@(posedge clock) disable iff (!nrst)
      (wrCsr && ioReq.wdata[`ADCC_CSR_IF] && !convDone) |=> !doneFlag_q)
      else $error("flag not cleared");
   a_lock_holds: assert property (@(posedge clock) disable iff (!nrst)
      lock_q |=> $stable(result_q)) else $error("locked result changed");
   a_free_restart: assert property (@(posedge clock) disable iff (!nrst)
      (convDone && freeRun && enNext) |=> (busy && convStart))
      else $error("free run stopped");
   a_no_auto_trig: assert property (@(posedge clock) disable iff (!nrst)
      (!autoTrig_q && !busy && !swStart) |=> !busy) else $error("stray start");
endmodule

`default_nettype wire

//--- core/adcc_params.svh
/*
 * Register offsets, bit positions, reset values and cycle counts for the
 * converter control block.
 * Assumes: included by bare name from the package and the design file.
 */
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// ==========================================================
// Register offsets on the I/O bus
`define ADCC_OFF_RESL 6'h04
`define ADCC_OFF_RESH 6'h05
`define ADCC_OFF_CSR 6'h06
`define ADCC_OFF_MUX 6'h07
`define ADCC_OFF_SFIO 6'h30

// ==========================================================
// Field positions
`define ADCC_CSR_EN 7
`define ADCC_CSR_SC 6
`define ADCC_CSR_ATE 5
`define ADCC_CSR_IF 4
`define ADCC_CSR_IE 3
`define ADCC_MUX_LAR 5
`define ADCC_SFIO_TS 7:5
`define ADCC_CSR_PS 2:0
`define ADCC_MUX_CH 4:0
`define ADCC_MUX_REF 7:6

// ==========================================================
// Reset values and counts
`define ADCC_RST_BYTE 8'h00
`define ADCC_RST_RES 10'h000
`define ADCC_FIRST_CYCLES 5'd25
`define ADCC_NORM_CYCLES 5'd13
`define ADCC_TS_FREE 3'h0
`define ADCC_PS_MIN_SHIFT 3'h1

`endif

//--- core/adcc_pkg.sv
/*
 * Types shared by the converter control block.
 * Assumes: adcc_params.svh is reachable on the include path.
 */
`include "adcc_params.svh"

package adcc_pkg;

   // ==========================================================
   // One access on the CPU I/O bus
   typedef struct packed {
      logic [5:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } adcc_io_req_t;

   // ==========================================================
   // Interrupt flags of the event sources, index = select code minus one
   typedef struct packed {
      logic t1Capture;
      logic t1Overflow;
      logic t1CompareB;
      logic t0Overflow;
      logic t0Compare;
      logic extInt0;
      logic analogComp;
   } adcc_trig_flags_t;

   // ==========================================================
   // Sequencer states
   typedef enum logic [0:0] {
      ADCC_IDLE,
      ADCC_CONV
   } adcc_state_t;

endpackage

//--- testbench/adcc_far_side.sv
/*
 * Far-side stand-in for the analog core: holds one sample per conversion.
 * Assumes: convStart pulses once as each conversion begins.
 */
`timescale 1ns/10ps
`default_nettype none
module adcc_far_side (
   input wire logic clock,
   input wire logic nrst,
   input wire logic convStart,
   input wire logic converterOn,
   input wire logic [9:0] sampleIn,
   output logic [9:0] sarResult
);
   // ==========================================
   // Sample capture
   logic [9:0] held;
   // Latch at start so the value is stable on the end cycle
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         held <= 10'h000;
      end else if (convStart) begin
         held <= sampleIn;
      end
   end
   // Powered down there is no valid sample, so show the inverse
   assign sarResult = converterOn ? held : ~held;
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
/*
 * Self-checking bench for the converter control block.
 * Assumes: adcc_pkg and the far-side model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import adcc_pkg::*;
   // ==========================================
   // Signals and bench model state
   logic clock, nrst, gie, vecAck, locked, lar;
   adcc_io_req_t ioReq;
   adcc_trig_flags_t trigFlags;
   logic [7:0] ioRdata, rv;
   logic [9:0] sarResult, sampleIn, expRes;
   logic irqRequest, converterOn, convStart;
   logic [4:0] activeChannel;
   logic [1:0] activeReference;
   logic [5:0] addrs [6] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h30, 6'h11};
   int n_mismatch = 0, n_tests = 0, cyc = 0, c0, d, t, dv, n;
   adcc_conversion_control u_adcc_conversion_control (.clock(clock), .nrst(nrst),
      .ioReq(ioReq), .ioRdata(ioRdata), .trigFlags(trigFlags), .globalIrqEnable(gie),
      .irqVectorAck(vecAck), .sarResult(sarResult), .irqRequest(irqRequest),
      .converterOn(converterOn), .convStart(convStart), .activeChannel(activeChannel),
      .activeReference(activeReference));
   adcc_far_side u_adcc_far_side (.clock(clock), .nrst(nrst), .convStart(convStart),
      .converterOn(converterOn), .sampleIn(sampleIn), .sarResult(sarResult));
   // Clock and a cycle count for timing
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) cyc <= cyc + 1;
   // ==========================================
   // Shared tasks
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(logic [5:0] a, logic [7:0] dt);
      @(negedge clock);
      ioReq = '{a, 1'b1, 1'b0, dt};
      sampleIn = 10'($urandom);
      @(negedge clock);
      ioReq.wr = 1'b0;
   endtask
   // Read data is registered, so it is taken one full cycle later
   task automatic rd(logic [5:0] a);
      @(negedge clock);
      ioReq = '{a, 1'b0, 1'b1, 8'h00};
      @(negedge clock);
      ioReq.rd = 1'b0;
      @(negedge clock);
      rv = ioRdata;
   endtask
   // Bounded wait for start (w=0) or interrupt (w=1); d is -1 if none
   task automatic waitv(int w, int lim);
      c0 = cyc;
      d = -1;
      repeat (lim) begin
         if ((w == 0 ? convStart : irqRequest) === 1'b1) begin
            d = cyc - c0;
            return;
         end
         @(negedge clock);
      end
   endtask
   // One conversion with interrupt enabled; t counts from the start pulse
   // to the interrupt, skipping two cycles so a stale request is not seen
   task automatic conv(logic [7:0] csr);
      wr(6'h06, csr);
      waitv(0, 6);
      chk("start", 16'(d == 0), 16'h1);
      repeat (2) @(negedge clock);
      waitv(1, 3000);
      t = (d < 0) ? -1 : d + 2;
      if (!locked) expRes = sampleIn;
   endtask
   // Pair read, low first; mid runs a conversion between the halves
   task automatic rdres(bit mid);
      rd(6'h04);
      chk("low", rv, lar ? {expRes[1:0], 6'h00} : expRes[7:0]);
      if (mid) begin
         locked = 1'b1;
         conv(8'hD8);
         locked = 1'b0;
      end
      rd(6'h05);
      chk("high", rv, lar ? expRes[9:2] : {6'h00, expRes[9:8]});
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Watchdog: the whole sequence needs well under 12000 cycles
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      give_verdict;
   end
   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(33));
      {nrst, vecAck, locked, lar} = 4'h0;
      gie = 1'b1;
      ioReq = '0;
      trigFlags = '0;
      sampleIn = '0;
      expRes = '0;
      repeat (8) @(posedge clock);
      @(negedge clock);
      nrst = 1'b1;
      foreach (addrs[i]) begin
         rd(addrs[i]);
         chk("reset", rv, 8'h00);
      end
      $display("test reset done");
      // Long first conversion against a normal one
      // 25 ticks of two clocks from the start pulse, then one cycle to the interrupt
      conv(8'hD8);
      chk("long", 16'(t), 16'(1 + 25 * 2));
      conv(8'hD8);
      chk("norm", 16'(t / 2), 16'd13);
      rd(6'h06);
      chk("csr", rv, 8'h98);
      rdres(0);
      $display("test first done");
      // Channel change mid-conversion, then justify flips
      wr(6'h06, 8'hD8);
      expRes = sampleIn;
      wr(6'h07, 8'hE9);
      chk("chan", activeChannel, 5'h00);
      chk("ref", activeReference, 2'h0);
      waitv(1, 300);
      chk("chan", activeChannel, 5'h09);
      chk("ref", activeReference, 2'h3);
      lar = 1'b1;
      rdres(0);
      wr(6'h07, 8'h09);
      lar = 1'b0;
      rdres(0);
      $display("test justify done");
      // Interrupt gating, vector clear, write-one clear
      gie = 1'b0;
      repeat (2) @(negedge clock);
      chk("irq", irqRequest, 1'b0);
      gie = 1'b1;
      repeat (2) @(negedge clock);
      chk("irq", irqRequest, 1'b1);
      vecAck = 1'b1;
      @(negedge clock);
      vecAck = 1'b0;
      rd(6'h06);
      chk("ack", rv, 8'h88);
      conv(8'hD8);
      wr(6'h06, 8'h98);
      rd(6'h06);
      chk("w1c", rv, 8'h88);
      chk("irq", irqRequest, 1'b0);
      $display("test flag done");
      // Low read locks the pair across a finishing conversion
      rdres(1);
      rdres(0);
      conv(8'hD8);
      rdres(0);
      $display("test lock done");
      for (int ps = 1; ps < 8; ps++) begin
         dv = (ps < 2) ? 2 : (1 << ps);
         conv(8'hD8 | 8'(ps));
         // Tick phase is free here, so the first tick lands 1 to dv clocks in
         chk("ticks", 16'((t + dv - 2) / dv), 16'd13);
      end
      $display("test prescale done");
      // Trigger sources: ignored without auto trigger, then each one
      wr(6'h30, 8'h20);
      wr(6'h06, 8'h98);
      trigFlags[0] = 1'b1;
      waitv(0, 10);
      chk("noauto", 16'(d < 0), 16'h1);
      trigFlags = '0;
      for (int s = 1; s < 8; s++) begin
         wr(6'h30, 8'(s << 5));
         wr(6'h06, 8'hB8);
         trigFlags[s-1] = 1'b1;
         waitv(0, 6);
         chk("trig", 16'(d >= 0), 16'h1);
         waitv(1, 300);
         trigFlags = '0;
      end
      wr(6'h30, 8'h20);
      wr(6'h06, 8'hB8);
      trigFlags[1] = 1'b1;
      wr(6'h30, 8'h40);
      waitv(0, 6);
      chk("switch", 16'(d >= 0), 16'h1);
      waitv(1, 300);
      trigFlags = '0;
      wr(6'h30, 8'h00);
      waitv(0, 20);
      chk("freesel", 16'(d < 0), 16'h1);
      $display("test trigger done");
      // Mid-run reset returns every register to its reset value
      nrst = 1'b0;
      @(negedge clock);
      nrst = 1'b1;
      foreach (addrs[i]) begin
         rd(addrs[i]);
         chk("reset2", rv, 8'h00);
      end
      chk("irqrst", irqRequest, 1'b0);
      $display("test rerun reset done");
      // Free running restarts alone; disable aborts it
      wr(6'h06, 8'hF8);
      n = 0;
      repeat (300) begin
         @(negedge clock);
         if (convStart === 1'b1) n++;
      end
      chk("free", 16'(n > 2), 16'h1);
      wr(6'h06, 8'h10);
      chk("power", converterOn, 1'b0);
      rd(6'h06);
      chk("abort", rv & 8'hEF, 8'h00);
      waitv(0, 100);
      chk("off", 16'(d < 0), 16'h1);
      conv(8'hD8);
      chk("relong", 16'(t), 16'(1 + 25 * 2));
      $display("test free done");
      give_verdict;
   end
endmodule
`default_nettype wire
